// [src/tx_seg_mac.sv]
// mac transmit entry: segment sampling, packet tracking and line word selection
//
// Functional notes
// [R1] every segment has own end, bad, empty
// [R2] user marks bad only on last transfer
// [R3] bad sampled only with qualifier and end
// [R4] bad packet ends with error code word
// [R5] bad packet skips frame check, that packet only
// [R6] four bit empty count on last transfer
// [R7] empty sampled only with qualifier and end
// [R8] bad end forces low three empty bits zero
// [R9] enable low: only idles, no new packets
// [R10] enable drop mid packet finishes that packet
// [R11] user keeps enable low until partner ready
// [R12] local fault request sends only fault words
// [R13] segment signals sampled only with qualifier
// [R14] 128 bit data captured when qualifier high
// [R15] user marks first with start, last end
// [R16] underrun flags underflow, sends error words
// [R17] local fault wins over transmit enable
//
// The register offsets and register access over APB were chosen for this implementation.
module tx_seg_mac #(
	parameter int CNT_W = tx_seg_pkg::CNT_W
) (
	input  wire logic                           core_clk,                 // core clock
	input  wire logic                           nrst,                     // sync reset
	tx_seg_if.dev                               seg_bus,                  // packet bus
	output tx_seg_pkg::word_kind_t              line_kind  [tx_seg_pkg::NUM_SEG], // word kind
	output logic [tx_seg_pkg::SEG_W-1:0]        line_data  [tx_seg_pkg::NUM_SEG], // word data
	output logic [tx_seg_pkg::EMPTY_W-1:0]      line_empty [tx_seg_pkg::NUM_SEG], // empty bytes
	output logic [tx_seg_pkg::NUM_SEG-1:0]      line_last,                // packet end
	output logic [tx_seg_pkg::NUM_SEG-1:0]      fcs_skip,                 // no fcs check
	output logic                                underflow_out,            // underrun level
	output logic [CNT_W-1:0]                    pkt_count,                // packets sent
	output logic [CNT_W-1:0]                    bad_count,                // packets errored
	output logic [CNT_W-1:0]                    drop_count                // starts refused
);
	localparam int N = tx_seg_pkg::NUM_SEG;

	// ----------------------------------------------------------------
	// packet state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_PACKET, ST_CORRUPT} tx_state_t;

	tx_state_t                          state_q;
	tx_state_t                          state_d;
	tx_seg_pkg::word_kind_t             kind_q  [N];
	tx_seg_pkg::word_kind_t             kind_d  [N];
	logic [tx_seg_pkg::SEG_W-1:0]       data_q  [N];
	logic [tx_seg_pkg::SEG_W-1:0]       data_d  [N];
	logic [tx_seg_pkg::EMPTY_W-1:0]     empty_q [N];
	logic [tx_seg_pkg::EMPTY_W-1:0]     empty_d [N];
	logic [N-1:0]                       last_q;
	logic [N-1:0]                       last_d;
	logic [N-1:0]                       skip_q;
	logic [N-1:0]                       skip_d;
	logic                               under_q;
	logic                               under_d;
	logic [2:0]                         n_pkt;
	logic [2:0]                         n_bad;
	logic [2:0]                         n_drop;
	logic [CNT_W-1:0]                   pkt_q;
	logic [CNT_W-1:0]                   bad_q;
	logic [CNT_W-1:0]                   drop_q;
	wire                                lf_req;
	wire                                enable;

	assign lf_req = seg_bus.local_fault_req;
	assign enable = seg_bus.tx_enable;

	// ----------------------------------------------------------------
	// segment walk, lowest segment first within a cycle
	// ----------------------------------------------------------------
	always_comb begin
		tx_state_t st;
		logic      is_bad;
		st      = state_q;
		is_bad  = 1'b0;
		under_d = 1'b0;
		n_pkt   = 3'h0;
		n_bad   = 3'h0;
		n_drop  = 3'h0;
		for (int i = 0; i < N; i++) begin
			kind_d[i]  = tx_seg_pkg::KIND_IDLE;
			data_d[i]  = '0;
			empty_d[i] = '0;
			last_d[i]  = 1'b0;
			skip_d[i]  = 1'b0;
			is_bad     = 1'b0;
			if (!seg_bus.valid[i]) begin // see [R13]
				// a gap inside a packet is an underrun; the packet can no longer be trusted
				if (st != ST_IDLE) begin
					under_d   = 1'b1; // see [R16]
					kind_d[i] = tx_seg_pkg::KIND_ERROR; // see [R16]
					st        = ST_CORRUPT;
				end
			end else begin
				if (st == ST_IDLE && seg_bus.sop[i]) begin
					// enable only gates the start, so a packet under way always completes
					if (enable) begin // see [R9] [R10]
						st = ST_PACKET;
					end else begin
						n_drop = n_drop + 3'h1;
					end
				end
				if (st != ST_IDLE) begin
					kind_d[i] = tx_seg_pkg::KIND_DATA;
					data_d[i] = seg_bus.data[i]; // see [R14]
					if (seg_bus.eop[i]) begin // see [R1]
						is_bad     = seg_bus.bad[i] || st == ST_CORRUPT; // see [R3]
						last_d[i]  = 1'b1;
						empty_d[i] = seg_bus.empty[i]; // see [R6] [R7]
						if (is_bad) begin
							kind_d[i] = tx_seg_pkg::KIND_ERROR; // see [R4]
							data_d[i] = '0;
							skip_d[i] = 1'b1; // see [R5]
							empty_d[i][tx_seg_pkg::EMPTY_LOW-1:0] = '0; // see [R8]
							n_bad = n_bad + 3'h1;
						end
						n_pkt = n_pkt + 3'h1;
						st    = ST_IDLE; // see [R5]
					end
				end
			end
			// fault words replace everything, whatever enable says
			if (lf_req) begin
				kind_d[i] = tx_seg_pkg::KIND_LFAULT; // see [R12] [R17]
				data_d[i] = '0;
				last_d[i] = 1'b0;
				skip_d[i] = 1'b0;
				empty_d[i] = '0;
			end
		end
		state_d = st;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			under_q <= 1'b0;
			last_q  <= '0;
			skip_q  <= '0;
		end else begin
			state_q <= state_d;
			under_q <= under_d;
			last_q  <= last_d;
			skip_q  <= skip_d;
		end
	end

	always_ff @(posedge core_clk) begin
		for (int i = 0; i < N; i++) begin
			if (!nrst) begin
				kind_q[i]  <= tx_seg_pkg::KIND_IDLE;
				data_q[i]  <= '0;
				empty_q[i] <= '0;
			end else begin
				kind_q[i]  <= kind_d[i];
				data_q[i]  <= data_d[i];
				empty_q[i] <= empty_d[i];
			end
		end
	end

	// counters wrap; software is expected to sample them often enough
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pkt_q  <= '0;
			bad_q  <= '0;
			drop_q <= '0;
		end else begin
			pkt_q  <= pkt_q + CNT_W'(n_pkt);
			bad_q  <= bad_q + CNT_W'(n_bad);
			drop_q <= drop_q + CNT_W'(n_drop);
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign line_kind         = kind_q;
	assign line_data         = data_q;
	assign line_empty        = empty_q;
	assign line_last         = last_q;
	assign fcs_skip          = skip_q;
	assign underflow_out     = under_q;
	assign seg_bus.underflow = under_q;
	assign pkt_count         = pkt_q;
	assign bad_count         = bad_q;
	assign drop_count        = drop_q;
endmodule

// [src/tx_seg_pkg.sv]
// shared constants and types of the segmented packet bus and its controller
package tx_seg_pkg;
	// ----------------------------------------------------------------
	// bus shape
	// ----------------------------------------------------------------
	localparam int NUM_SEG   = 4;
	localparam int SEG_W     = 128;
	localparam int EMPTY_W   = 4;
	localparam int SEG_BYTES = 16;
	localparam int LEN_W     = 16;
	localparam int CNT_W     = 16;
	// the error marker clears the low bits of the empty count
	localparam int EMPTY_LOW = 3;

	// ----------------------------------------------------------------
	// controller registers (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  OFF_CTRL    = 8'h00;
	localparam logic [7:0]  OFF_LEN     = 8'h04;
	localparam logic [7:0]  OFF_GO      = 8'h08;
	localparam logic [7:0]  OFF_STATUS  = 8'h0c;
	localparam logic [7:0]  OFF_MASK    = 8'h10;
	localparam int          CTRL_EN     = 0;
	localparam int          CTRL_LF     = 1;
	localparam int          CTRL_BAD    = 2;
	localparam int          CTRL_BUSY   = 8;
	localparam int          CTRL_W      = 3;
	localparam int          ST_DONE     = 0;
	localparam int          ST_UNDER    = 1;
	localparam int          ST_W        = 2;
	localparam logic [2:0]  CTRL_RESET  = 3'h0;
	localparam logic [15:0] LEN_RESET   = 16'h0040;
	localparam logic [1:0]  MASK_RESET  = 2'h0;

	// ----------------------------------------------------------------
	// line code word kinds
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {KIND_IDLE, KIND_DATA, KIND_ERROR, KIND_LFAULT} word_kind_t;
endpackage

// [src/tx_seg_if.sv]
// segmented packet bus between user transmit logic and the mac transmit entry
interface tx_seg_if;
	logic [tx_seg_pkg::NUM_SEG-1:0]   valid;
	logic [tx_seg_pkg::NUM_SEG-1:0]   sop;
	logic [tx_seg_pkg::NUM_SEG-1:0]   eop;
	logic [tx_seg_pkg::NUM_SEG-1:0]   bad;
	logic [tx_seg_pkg::EMPTY_W-1:0]   empty [tx_seg_pkg::NUM_SEG];
	logic [tx_seg_pkg::SEG_W-1:0]     data  [tx_seg_pkg::NUM_SEG];
	logic                             tx_enable;
	logic                             local_fault_req;
	logic                             underflow;

	modport dev (
		input  valid,
		input  sop,
		input  eop,
		input  bad,
		input  empty,
		input  data,
		input  tx_enable,
		input  local_fault_req,
		output underflow
	);

	modport user (
		output valid,
		output sop,
		output eop,
		output bad,
		output empty,
		output data,
		output tx_enable,
		output local_fault_req,
		input  underflow
	);
endinterface

// [src/tx_seg_user.sv]
// user transmit logic: apb registers, packet generator onto the segmented bus
module tx_seg_user (
	input  wire logic                           core_clk, // core clock
	input  wire logic                           nrst,     // sync reset
	tx_seg_if.user                              seg_bus,  // packet bus
	input  wire logic                           psel,     // apb select
	input  wire logic                           penable,  // apb enable
	input  wire logic                           pwrite,   // apb direction
	input  wire logic [tx_seg_pkg::ADDR_W-1:0]  paddr,    // apb address
	input  wire logic [31:0]                    pwdata,   // apb write data
	output logic [31:0]                         prdata,   // apb read data
	output logic                                pready,   // apb ready
	output logic                                pslverr,  // apb error
	output logic                                irq       // interrupt level
);
	localparam int N = tx_seg_pkg::NUM_SEG;
	localparam int L = tx_seg_pkg::LEN_W;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic [tx_seg_pkg::CTRL_W-1:0]  ctrl_q;
	logic [L-1:0]                   len_q;
	logic [tx_seg_pkg::ST_W-1:0]    status_q;
	logic [tx_seg_pkg::ST_W-1:0]    mask_q;
	logic [tx_seg_pkg::ST_W-1:0]    events;
	logic [L-1:0]                   rem_q;
	logic [L-1:0]                   word_q;
	logic                           busy_q;
	logic                           first_q;
	logic                           bad_pkt_q;
	logic [N-1:0]                   val_q, sop_q, eop_q, badm_q;
	logic [N-1:0]                   val_d, sop_d, eop_d, badm_d;
	logic [tx_seg_pkg::EMPTY_W-1:0] empty_q [N];
	logic [tx_seg_pkg::EMPTY_W-1:0] empty_d [N];
	logic [tx_seg_pkg::SEG_W-1:0]   data_q  [N];
	logic [tx_seg_pkg::SEG_W-1:0]   data_d  [N];
	wire                            access;
	wire                            hit_ctrl, hit_len, hit_go, hit_status, hit_mask;
	wire                            wr, rd_status, start, final_cycle;

	assign access      = psel && penable;
	assign hit_ctrl    = paddr == tx_seg_pkg::OFF_CTRL;
	assign hit_len     = paddr == tx_seg_pkg::OFF_LEN;
	assign hit_go      = paddr == tx_seg_pkg::OFF_GO;
	assign hit_status  = paddr == tx_seg_pkg::OFF_STATUS;
	assign hit_mask    = paddr == tx_seg_pkg::OFF_MASK;
	assign wr          = access && pwrite;
	assign rd_status   = access && !pwrite && hit_status;
	assign start       = wr && hit_go && !busy_q && len_q != '0;
	assign final_cycle = busy_q && rem_q <= L'(N * tx_seg_pkg::SEG_BYTES);
	assign events      = {seg_bus.underflow, final_cycle};
	assign pready      = 1'b1;
	assign pslverr     = access && !(hit_ctrl || hit_len || hit_go || hit_status || hit_mask);
	assign prdata      = hit_ctrl   ? 32'(ctrl_q) | (32'(busy_q) << tx_seg_pkg::CTRL_BUSY) :
	                     hit_len    ? 32'(len_q) :
	                     hit_status ? 32'(status_q) :
	                     hit_mask   ? 32'(mask_q) : 32'h0;
	assign irq         = |(status_q & mask_q);

	// ----------------------------------------------------------------
	// registers; a new event wins over the read that clears
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ctrl_q   <= tx_seg_pkg::CTRL_RESET;
			len_q    <= tx_seg_pkg::LEN_RESET;
			mask_q   <= tx_seg_pkg::MASK_RESET;
			status_q <= '0;
		end else begin
			if (wr && hit_ctrl) ctrl_q <= pwdata[tx_seg_pkg::CTRL_W-1:0];
			if (wr && hit_len) len_q <= pwdata[L-1:0];
			if (wr && hit_mask) mask_q <= pwdata[tx_seg_pkg::ST_W-1:0];
			status_q <= (status_q & ~{tx_seg_pkg::ST_W{rd_status}}) | events;
		end
	end

	// ----------------------------------------------------------------
	// generator: packets always start on segment 0, segments fill in order
	// ----------------------------------------------------------------
	always_comb begin
		logic [L-1:0] lim;
		logic         v;
		logic         e;
		lim = '0;
		v   = 1'b0;
		e   = 1'b0;
		for (int i = 0; i < N; i++) begin
			lim        = L'((i + 1) * tx_seg_pkg::SEG_BYTES);
			v          = busy_q && rem_q > L'(i * tx_seg_pkg::SEG_BYTES);
			e          = v && rem_q <= lim;
			val_d[i]   = v;
			sop_d[i]   = v && first_q && i == 0; // see [R15]
			eop_d[i]   = e; // see [R15]
			badm_d[i]  = e && bad_pkt_q; // see [R2]
			empty_d[i] = e ? tx_seg_pkg::EMPTY_W'(lim - rem_q) : '0;
			data_d[i]  = v ? tx_seg_pkg::SEG_W'({word_q, 2'(i)}) : '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			busy_q    <= 1'b0;
			first_q   <= 1'b0;
			bad_pkt_q <= 1'b0;
			rem_q     <= '0;
			word_q    <= '0;
			val_q     <= '0;
			sop_q     <= '0;
			eop_q     <= '0;
			badm_q    <= '0;
		end else begin
			val_q  <= val_d;
			sop_q  <= sop_d;
			eop_q  <= eop_d;
			badm_q <= badm_d;
			if (start) begin
				busy_q    <= 1'b1;
				first_q   <= 1'b1;
				rem_q     <= len_q;
				bad_pkt_q <= ctrl_q[tx_seg_pkg::CTRL_BAD];
			end else if (busy_q) begin
				first_q <= 1'b0;
				word_q  <= word_q + L'(1);
				rem_q   <= final_cycle ? '0 : rem_q - L'(N * tx_seg_pkg::SEG_BYTES);
				busy_q  <= !final_cycle;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		for (int i = 0; i < N; i++) begin
			if (!nrst) begin
				empty_q[i] <= '0;
				data_q[i]  <= '0;
			end else begin
				empty_q[i] <= empty_d[i];
				data_q[i]  <= data_d[i];
			end
		end
	end

	assign seg_bus.valid           = val_q;
	assign seg_bus.sop             = sop_q;
	assign seg_bus.eop             = eop_q;
	assign seg_bus.bad             = badm_q;
	assign seg_bus.empty           = empty_q;
	assign seg_bus.data            = data_q;
	assign seg_bus.tx_enable       = ctrl_q[tx_seg_pkg::CTRL_EN]; // see [R11]
	assign seg_bus.local_fault_req = ctrl_q[tx_seg_pkg::CTRL_LF];
endmodule

// [dv/tx_seg_asserts.sv]
// concurrent checks on the segmented packet bus and the mac line outputs
module tx_seg_asserts (
	input wire logic                           core_clk,                           // clock
	input wire logic                           nrst,                               // reset
	input wire logic [tx_seg_pkg::NUM_SEG-1:0] valid,                              // qualifiers
	input wire logic [tx_seg_pkg::NUM_SEG-1:0] sop,                                // starts
	input wire logic [tx_seg_pkg::NUM_SEG-1:0] eop,                                // ends
	input wire logic [tx_seg_pkg::NUM_SEG-1:0] bad,                                // bad marks
	input wire logic [tx_seg_pkg::EMPTY_W-1:0] empty [tx_seg_pkg::NUM_SEG],        // empty
	input wire logic [tx_seg_pkg::SEG_W-1:0]   data [tx_seg_pkg::NUM_SEG],         // data
	input wire logic                           tx_enable,                          // enable
	input wire logic                           local_fault_req,                    // fault req
	input wire logic                           underflow,                          // underrun
	input tx_seg_pkg::word_kind_t              line_kind [tx_seg_pkg::NUM_SEG],    // kinds
	input wire logic [tx_seg_pkg::SEG_W-1:0]   line_data [tx_seg_pkg::NUM_SEG],    // words
	input wire logic [tx_seg_pkg::EMPTY_W-1:0] line_empty [tx_seg_pkg::NUM_SEG],   // empties
	input wire logic [tx_seg_pkg::NUM_SEG-1:0] line_last,                          // ends out
	input wire logic [tx_seg_pkg::NUM_SEG-1:0] fcs_skip                            // skips
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// ----------------------------------------------------------------
	// packet tracking: a start counts only when enabled and no packet open
	// ----------------------------------------------------------------
	logic open_q;
	logic open_d;
	wire  start_ok = valid[0] && sop[0] && tx_enable && !open_q;
	assign open_d = (open_q || start_ok) && !(|(valid & eop));
	always_ff @(posedge core_clk) begin
		if (!nrst) open_q <= 1'b0;
		else open_q <= open_d;
	end
	// ----------------------------------------------------------------
	// bus wide checks
	// ----------------------------------------------------------------
	chk_marks_qualified: assert property (((sop | eop | bad) & ~valid) == 4'h0)
		else $error("marker on unqualified segment");
	chk_bad_on_end: assert property ((bad & ~eop) == 4'h0)
		else $error("bad marker away from packet end");
	chk_lfault_only: assert property (local_fault_req
		|=> line_kind[0] == tx_seg_pkg::KIND_LFAULT && line_kind[1] == tx_seg_pkg::KIND_LFAULT
		&& line_kind[2] == tx_seg_pkg::KIND_LFAULT && line_kind[3] == tx_seg_pkg::KIND_LFAULT)
		else $error("non fault word under fault request");
	chk_idle_when_off: assert property (!open_q && !tx_enable && !local_fault_req
		|=> line_kind[0] == tx_seg_pkg::KIND_IDLE && line_last == 4'h0)
		else $error("traffic while disabled");
	chk_finish_open: assert property (open_q && !tx_enable && !local_fault_req
		&& valid[0] |=> line_kind[0] != tx_seg_pkg::KIND_IDLE)
		else $error("open packet cut by disable");
	// a packet may open and underrun within one cycle, so the start counts as open
	chk_under_cause: assert property ($rose(underflow) |-> $past(open_q || start_ok))
		else $error("underflow without open packet");
	// ----------------------------------------------------------------
	// per segment end handling and data word capture
	// ----------------------------------------------------------------
	for (genvar i = 0; i < tx_seg_pkg::NUM_SEG; i++) begin : g_seg
		sequence s_end;
			valid[i] && eop[i] && !local_fault_req && (open_q || start_ok);
		endsequence
		chk_bad_end: assert property (s_end ##0 bad[i]
			|=> line_kind[i] == tx_seg_pkg::KIND_ERROR && fcs_skip[i] && line_last[i]
			&& line_empty[i] == {$past(empty[i][3]), 3'h0})
			else $error("bad end not marked");
		chk_good_end: assert property (s_end ##0 !bad[i]
			|=> !fcs_skip[i] && line_last[i] && line_empty[i] == $past(empty[i]))
			else $error("good end wrong");
		chk_data_copy: assert property (line_kind[i] == tx_seg_pkg::KIND_DATA
			|-> line_data[i] == $past(data[i]) && $past(valid[i]))
			else $error("data word not captured");
	end
endmodule

// [dv/test_tx_segment_bus_packet_control.sv]
// self-checking bench: user generator and mac entry joined by the packet bus
module test_tx_segment_bus_packet_control;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic                   core_clk;
	logic                   nrst;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic [7:0]             paddr;
	logic [31:0]            pwdata;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	logic                   irq;
	tx_seg_pkg::word_kind_t line_kind [4];
	logic [127:0]           line_data [4];
	logic [3:0]             line_empty [4];
	logic [3:0]             line_last;
	logic [3:0]             fcs_skip;
	logic                   underflow_out;
	logic [15:0]            pkt_count;
	logic [15:0]            bad_count;
	logic [15:0]            drop_count;
	logic                   mask_on;
	int                     error_cnt;
	int                     n_checks;
	int                     seed;
	int                     cycles;
	tx_seg_if bus ();
	tx_seg_user tx_seg_user_i (.core_clk, .nrst, .seg_bus(bus), .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
	tx_seg_mac tx_seg_mac_i (.core_clk, .nrst, .seg_bus(bus), .line_kind, .line_data,
		.line_empty, .line_last, .fcs_skip, .underflow_out, .pkt_count, .bad_count, .drop_count);
	tx_seg_asserts tx_seg_asserts_i (.core_clk, .nrst, .valid(bus.valid), .sop(bus.sop),
		.eop(bus.eop), .bad(bus.bad), .empty(bus.empty), .data(bus.data),
		.tx_enable(bus.tx_enable), .local_fault_req(bus.local_fault_req),
		.underflow(bus.underflow), .line_kind, .line_data, .line_empty, .line_last, .fcs_skip);
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// ----------------------------------------------------------------
	// reporting
	// ----------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	// hangs are cut well beyond the longest expected run
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			results();
		end
	end
	// ----------------------------------------------------------------
	// apb master and packet scenario
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		// this wait ends once pready is seen high; pready is tied high, so after one edge
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [3:0] exp_empty(input int len, input logic bad);
		exp_empty = 4'(16 * ((len + 15) / 16) - len);
		if (bad) exp_empty = exp_empty & 4'h8;
	endfunction
	task automatic send(input int len, input logic bad, input logic en, input logic cut);
		logic [31:0] rd;
		logic        e;
		int          n;
		int          s;
		logic [15:0] p0;
		logic [15:0] b0;
		logic [15:0] d0;
		p0 = pkt_count;
		b0 = bad_count;
		d0 = drop_count;
		s = ((len + 15) / 16 - 1) % 4;
		apb(1'b1, tx_seg_pkg::OFF_CTRL, {29'h0, bad, 1'b0, en}, rd, e);
		apb(1'b1, tx_seg_pkg::OFF_LEN, 32'(len), rd, e);
		apb(1'b1, tx_seg_pkg::OFF_GO, 32'h1, rd, e);
		if (cut) apb(1'b1, tx_seg_pkg::OFF_CTRL, 32'h0, rd, e);
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (line_last === 4'h0 && n < 100);
		if (en) begin
			chk(line_last === 4'h1 << s, "end segment");
			chk(line_empty[s] === exp_empty(len, bad), "empty count");
			chk(fcs_skip[s] === bad, "fcs skip");
			chk(line_kind[s] === (bad ? tx_seg_pkg::KIND_ERROR : tx_seg_pkg::KIND_DATA), "kind");
		end else chk(n == 100, "refused packet sent");
		repeat (3) @(negedge core_clk);
		chk(pkt_count === p0 + 16'(en), "packet count");
		chk(bad_count === b0 + 16'(en & bad), "bad count");
		chk(drop_count === d0 + 16'(!en), "drop count");
		chk(irq === mask_on, "irq level");
		apb(1'b0, tx_seg_pkg::OFF_STATUS, 32'h0, rd, e);
		chk(rd[tx_seg_pkg::ST_DONE] === 1'b1, "done status");
		chk(underflow_out === 1'b0 && rd[tx_seg_pkg::ST_UNDER] === 1'b0, "no underrun");
		@(negedge core_clk);
		chk(irq === 1'b0, "irq after clear");
	endtask
	initial begin
		logic [31:0] rd;
		logic        e;
		int          lens [6] = '{1, 16, 20, 64, 65, 200};
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{nrst, mask_on, error_cnt, n_checks, cycles} = '0;
		seed = 32'h28ad;
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		apb(1'b0, tx_seg_pkg::OFF_LEN, 32'h0, rd, e);
		chk(rd === {16'h0, tx_seg_pkg::LEN_RESET} && e === 1'b0, "len reset");
		apb(1'b0, tx_seg_pkg::OFF_CTRL, 32'h0, rd, e);
		chk(rd === 32'h0, "ctrl reset");
		apb(1'b0, 8'h14, 32'h0, rd, e);
		chk(e === 1'b1 && rd === 32'h0, "unmapped read");
		send(20, 1'b0, 1'b1, 1'b0);
		apb(1'b1, tx_seg_pkg::OFF_MASK, 32'h1, rd, e);
		mask_on = 1'b1;
		foreach (lens[k]) send(lens[k], 1'(k), 1'b1, 1'b0);
		send(30, 1'b0, 1'b0, 1'b0);
		send(200, 1'b1, 1'b1, 1'b1);
		repeat (20) send(1 + $unsigned($random(seed)) % 200, 1'($random(seed)),
			($random(seed) & 3) != 0, 1'b0);
		apb(1'b1, tx_seg_pkg::OFF_CTRL, 32'h3, rd, e);
		repeat (3) @(negedge core_clk);
		for (int i = 0; i < 4; i++) chk(line_kind[i] === tx_seg_pkg::KIND_LFAULT, "fault");
		apb(1'b1, tx_seg_pkg::OFF_CTRL, 32'h1, rd, e);
		results();
	end
endmodule
